// File: core/oc_defines.vh
// register map, field positions, mode codes and reset values for the compare channel
`ifndef OC_DEFINES_VH
`define OC_DEFINES_VH

`define OC_ADDR_W          4
`define OC_DATA_W          16

`define OC_REG_CTRL        4'h0
`define OC_REG_PRIMARY     4'h1
`define OC_REG_SECONDARY   4'h2
`define OC_REG_T1_COUNT    4'h3
`define OC_REG_T1_PERIOD   4'h4
`define OC_REG_T1_CTRL     4'h5
`define OC_REG_T2_COUNT    4'h6
`define OC_REG_T2_PERIOD   4'h7
`define OC_REG_T2_CTRL     4'h8
`define OC_REG_EVENT       4'h9

`define OC_CTRL_MODE_LSB   0
`define OC_CTRL_MODE_MSB   2
`define OC_CTRL_TBSEL_BIT  3
`define OC_CTRL_FAULT_BIT  4
`define OC_CTRL_IDLE_BIT   13
`define OC_TCTRL_RUN_BIT   15
`define OC_EVT_FLAG_BIT    0
`define OC_EVT_IE_BIT      1

`define OC_MODE_OFF        3'h0
`define OC_MODE_SET_HIGH   3'h1
`define OC_MODE_SET_LOW    3'h2
`define OC_MODE_TOGGLE     3'h3
`define OC_MODE_SINGLE     3'h4
`define OC_MODE_CONT       3'h5
`define OC_MODE_PWM        3'h6
`define OC_MODE_PWM_FAULT  3'h7

`define OC_RST_WORD        16'h0000
`define OC_RST_MODE        3'h0

`endif

// File: core/sync_two_ff.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module sync_two_ff (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // level in and out
    input  wire async_in,
    output reg  sync_out
);

    reg stage1;

    // resets to the idle-high level of an active-low pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// File: core/shared_timer.v
// one 16-bit shared time base with period register and wrap to zero
`timescale 1ns/10ps
`default_nettype none
`include "oc_defines.vh"

module shared_timer (
    // clock and reset
    input  wire                  clk,
    input  wire                  rst,
    // software side
    input  wire                  timer_run,
    input  wire                  wr_count,
    input  wire                  wr_period,
    input  wire [`OC_DATA_W-1:0] wdata,
    // time base state
    output reg  [`OC_DATA_W-1:0] time_base_count,
    output reg  [`OC_DATA_W-1:0] timer_period_value,
    output wire                  tick,
    output wire                  period_match
);

    // the count advances on every clock while running; no prescaler
    assign tick         = timer_run & ~wr_count;
    assign period_match = tick & (time_base_count == timer_period_value);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            time_base_count    <= `OC_RST_WORD;
            timer_period_value <= `OC_RST_WORD;
        end else begin
            if (wr_period) begin
                timer_period_value <= wdata;
            end
            if (wr_count) begin
                time_base_count <= wdata;
            end else if (period_match) begin
                time_base_count <= `OC_RST_WORD;
            end else if (tick) begin
                time_base_count <= time_base_count + 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// File: core/output_compare_pulse_pwm.v
// output compare channel: single/continuous pulses and double-buffered pwm
`timescale 1ns/10ps
`default_nettype none
`include "oc_defines.vh"

module output_compare_pulse_pwm (
    // clock and reset
    input  wire                  clk,
    input  wire                  rst,
    // register port
    input  wire [`OC_ADDR_W-1:0] addr,
    input  wire [`OC_DATA_W-1:0] wdata,
    input  wire                  wr,
    input  wire                  rd,
    output reg  [`OC_DATA_W-1:0] rdata,
    // pins
    input  wire                  pwm_fault_n,
    output reg                   compare_output_pin,
    output wire                  compare_irq
);

    localparam ST_IDLE      = 2'h0;
    localparam ST_WAIT_RISE = 2'h1;
    localparam ST_WAIT_FALL = 2'h2;
    localparam ST_DONE      = 2'h3;

    // control and compare registers
    reg  [2:0]            compare_mode_select;
    reg                   time_base_select;
    reg                   pwm_fault_status;
    reg                   idle_stop;
    reg  [`OC_DATA_W-1:0] primary_compare_value;
    reg  [`OC_DATA_W-1:0] secondary_compare_value;
    reg                   compare_event_flag;
    reg                   compare_event_irq_enable;
    reg                   first_timer_run;
    reg                   second_timer_run;
    reg  [1:0]            state;

    // decoded strobes
    wire wr_ctrl;
    wire wr_primary;
    wire wr_secondary;
    wire wr_event;
    wire wr_t1_count;
    wire wr_t1_period;
    wire wr_t1_ctrl;
    wire wr_t2_count;
    wire wr_t2_period;
    wire wr_t2_ctrl;

    assign wr_ctrl      = wr & (addr == `OC_REG_CTRL);
    assign wr_primary   = wr & (addr == `OC_REG_PRIMARY);
    assign wr_secondary = wr & (addr == `OC_REG_SECONDARY);
    assign wr_event     = wr & (addr == `OC_REG_EVENT);
    assign wr_t1_count  = wr & (addr == `OC_REG_T1_COUNT);
    assign wr_t1_period = wr & (addr == `OC_REG_T1_PERIOD);
    assign wr_t1_ctrl   = wr & (addr == `OC_REG_T1_CTRL);
    assign wr_t2_count  = wr & (addr == `OC_REG_T2_COUNT);
    assign wr_t2_period = wr & (addr == `OC_REG_T2_PERIOD);
    assign wr_t2_ctrl   = wr & (addr == `OC_REG_T2_CTRL);

    // the two shared time bases
    wire [`OC_DATA_W-1:0] t1_count;
    wire [`OC_DATA_W-1:0] t1_period;
    wire                  t1_tick;
    wire                  t1_pmatch;
    wire [`OC_DATA_W-1:0] t2_count;
    wire [`OC_DATA_W-1:0] t2_period;
    wire                  t2_tick;
    wire                  t2_pmatch;

    shared_timer first_shared_timer (
        .clk                (clk),
        .rst                (rst),
        .timer_run          (first_timer_run),
        .wr_count           (wr_t1_count),
        .wr_period          (wr_t1_period),
        .wdata              (wdata),
        .time_base_count    (t1_count),
        .timer_period_value (t1_period),
        .tick               (t1_tick),
        .period_match       (t1_pmatch)
    );

    shared_timer second_shared_timer (
        .clk                (clk),
        .rst                (rst),
        .timer_run          (second_timer_run),
        .wr_count           (wr_t2_count),
        .wr_period          (wr_t2_period),
        .wdata              (wdata),
        .time_base_count    (t2_count),
        .timer_period_value (t2_period),
        .tick               (t2_tick),
        .period_match       (t2_pmatch)
    );

    // fault pin is asynchronous to clk
    wire fault_n_sync;

    sync_two_ff fault_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pwm_fault_n),
        .sync_out (fault_n_sync)
    );

    // selected time base
    wire [`OC_DATA_W-1:0] sel_count;
    wire [`OC_DATA_W-1:0] sel_period;
    wire                  sel_tick;
    wire                  sel_pmatch;

    assign sel_count  = time_base_select ? t2_count  : t1_count;
    assign sel_period = time_base_select ? t2_period : t1_period;
    assign sel_tick   = time_base_select ? t2_tick   : t1_tick;
    assign sel_pmatch = time_base_select ? t2_pmatch : t1_pmatch;

    // matches are qualified by the increment so each value matches once
    wire primary_match;
    wire secondary_match;

    assign primary_match   = sel_tick & (sel_count == primary_compare_value);
    assign secondary_match = sel_tick & (sel_count == secondary_compare_value);

    // mode decode, including the mode being written this cycle
    wire [2:0] wmode;
    wire       pwm_mode;
    wire       pulse_mode;
    wire       pulse_start;

    assign wmode       = wdata[`OC_CTRL_MODE_MSB:`OC_CTRL_MODE_LSB];
    assign pwm_mode    = compare_mode_select[2] & compare_mode_select[1];
    assign pulse_mode  = (compare_mode_select == `OC_MODE_SINGLE) |
                         (compare_mode_select == `OC_MODE_CONT);
    // any write of a pulse code restarts, even if the code is unchanged
    assign pulse_start = wr_ctrl & ((wmode == `OC_MODE_SINGLE) |
                                    (wmode == `OC_MODE_CONT));

    // pwm next-period values seen after this increment
    wire [`OC_DATA_W-1:0] pwm_next_count;
    wire [`OC_DATA_W-1:0] pwm_next_duty;
    wire                  fault_hit;

    assign pwm_next_count = sel_pmatch ? `OC_RST_WORD : sel_count + 16'h0001;
    assign pwm_next_duty  = sel_pmatch ? secondary_compare_value
                                       : primary_compare_value;
    assign fault_hit      = (compare_mode_select == `OC_MODE_PWM_FAULT) & ~fault_n_sync;

    // control register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_mode_select <= `OC_RST_MODE;
            time_base_select    <= 1'b0;
            idle_stop           <= 1'b0;
            pwm_fault_status    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                compare_mode_select <= wmode;
                time_base_select    <= wdata[`OC_CTRL_TBSEL_BIT];
                idle_stop           <= wdata[`OC_CTRL_IDLE_BIT];
            end
            // status clears only when software writes a mode other than fault mode
            if (fault_hit) begin
                pwm_fault_status <= 1'b1;
            end else if (wr_ctrl & (wmode != `OC_MODE_PWM_FAULT)) begin
                pwm_fault_status <= 1'b0;
            end
        end
    end

    // compare value registers
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            primary_compare_value   <= `OC_RST_WORD;
            secondary_compare_value <= `OC_RST_WORD;
        end else begin
            if (wr_secondary) begin
                secondary_compare_value <= wdata;
            end
            if (pwm_mode) begin
                if (sel_pmatch) begin
                    primary_compare_value <= secondary_compare_value;
                end
            end else if (wr_primary) begin
                primary_compare_value <= wdata;
            end
        end
    end

    // timer run bits
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            first_timer_run  <= 1'b0;
            second_timer_run <= 1'b0;
        end else begin
            if (wr_t1_ctrl) begin
                first_timer_run <= wdata[`OC_TCTRL_RUN_BIT];
            end
            if (wr_t2_ctrl) begin
                second_timer_run <= wdata[`OC_TCTRL_RUN_BIT];
            end
        end
    end

    // event flag; hardware set beats a software clear in the same cycle
    wire compare_event;

    assign compare_event = (pulse_mode & (state == ST_WAIT_FALL) & secondary_match) |
                           ((compare_mode_select == `OC_MODE_SET_HIGH) & primary_match) |
                           ((compare_mode_select == `OC_MODE_SET_LOW) & primary_match) |
                           ((compare_mode_select == `OC_MODE_TOGGLE) & primary_match) |
                           (fault_hit & ~pwm_fault_status);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_event_flag       <= 1'b0;
            compare_event_irq_enable <= 1'b0;
        end else begin
            if (wr_event) begin
                compare_event_irq_enable <= wdata[`OC_EVT_IE_BIT];
            end
            if (compare_event) begin
                compare_event_flag <= 1'b1;
            end else if (wr_event & ~wdata[`OC_EVT_FLAG_BIT]) begin
                compare_event_flag <= 1'b0;
            end
        end
    end

    assign compare_irq = compare_event_flag & compare_event_irq_enable;

    // pulse sequencer and output pin
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state              <= ST_IDLE;
            compare_output_pin <= 1'b0;
        end else if (pulse_start) begin
            state              <= ST_WAIT_RISE;
            compare_output_pin <= 1'b0;
        end else if (wr_ctrl) begin
            state              <= ST_IDLE;
            // pwm starts low; first duty comes from the held primary value
            compare_output_pin <= (wmode == `OC_MODE_SET_LOW);
        end else if (pwm_mode) begin
            state <= ST_IDLE;
            if (fault_hit | pwm_fault_status) begin
                compare_output_pin <= 1'b0;
            end else if (sel_tick) begin
                // high while count below duty: 0 stays low, above period stays high
                compare_output_pin <= (pwm_next_count < pwm_next_duty);
            end
        end else if (pulse_mode) begin
            case (state)
                ST_WAIT_RISE: begin
                    if (primary_match) begin
                        compare_output_pin <= 1'b1;
                        state              <= ST_WAIT_FALL;
                    end
                end
                ST_WAIT_FALL: begin
                    if (secondary_match) begin
                        compare_output_pin <= 1'b0;
                        if (compare_mode_select == `OC_MODE_CONT) begin
                            state <= ST_WAIT_RISE;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                default: begin
                    compare_output_pin <= 1'b0;
                end
            endcase
        end else if (primary_match) begin
            state <= ST_IDLE;
            if (compare_mode_select == `OC_MODE_SET_HIGH) begin
                compare_output_pin <= 1'b1;
            end else if (compare_mode_select == `OC_MODE_SET_LOW) begin
                compare_output_pin <= 1'b0;
            end else if (compare_mode_select == `OC_MODE_TOGGLE) begin
                compare_output_pin <= ~compare_output_pin;
            end
        end
    end

    // read port: data stand one cycle after the strobe, zero otherwise
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= `OC_RST_WORD;
        end else if (rd) begin
            if (addr == `OC_REG_CTRL) begin
                rdata <= {2'b00, idle_stop, 8'h00, pwm_fault_status,
                          time_base_select, compare_mode_select};
            end else if (addr == `OC_REG_PRIMARY) begin
                rdata <= primary_compare_value;
            end else if (addr == `OC_REG_SECONDARY) begin
                rdata <= secondary_compare_value;
            end else if (addr == `OC_REG_T1_COUNT) begin
                rdata <= t1_count;
            end else if (addr == `OC_REG_T1_PERIOD) begin
                rdata <= t1_period;
            end else if (addr == `OC_REG_T1_CTRL) begin
                rdata <= {first_timer_run, 15'h0000};
            end else if (addr == `OC_REG_T2_COUNT) begin
                rdata <= t2_count;
            end else if (addr == `OC_REG_T2_PERIOD) begin
                rdata <= t2_period;
            end else if (addr == `OC_REG_T2_CTRL) begin
                rdata <= {second_timer_run, 15'h0000};
            end else if (addr == `OC_REG_EVENT) begin
                rdata <= {14'h0000, compare_event_irq_enable, compare_event_flag};
            end else begin
                rdata <= `OC_RST_WORD;
            end
        end else begin
            rdata <= `OC_RST_WORD;
        end
    end

endmodule

`default_nettype wire

// File: tb/output_compare_pulse_pwm_monitor.sv
// port checker for the output compare channel
`timescale 1ns/10ps
`default_nettype none
`include "oc_defines.vh"

module output_compare_monitor (
    // clock and reset
    input wire                  clk,
    input wire                  rst,
    // register port
    input wire [`OC_ADDR_W-1:0] addr,
    input wire [`OC_DATA_W-1:0] wdata,
    input wire                  wr,
    input wire                  rd,
    input wire [`OC_DATA_W-1:0] rdata,
    // pins
    input wire                  pwm_fault_n,
    input wire                  compare_output_pin,
    input wire                  compare_irq
);
    reg  [2:0] mode_q;
    reg        ie_q;
    reg        pin_q;
    reg        wr_q;
    reg        single_done;
    wire       ctrl_wr = wr && addr == `OC_REG_CTRL;
    wire       is_pwm  = mode_q[2] && mode_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // shadow of mode and enable; a fall caused by a rewrite is not a finished pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q      <= 3'h0;
            ie_q        <= 1'b0;
            pin_q       <= 1'b0;
            wr_q        <= 1'b0;
            single_done <= 1'b0;
        end else begin
            pin_q <= compare_output_pin;
            wr_q  <= ctrl_wr;
            if (ctrl_wr)
                mode_q <= wdata[2:0];
            if (wr && addr == `OC_REG_EVENT)
                ie_q <= wdata[`OC_EVT_IE_BIT];
            if (ctrl_wr)
                single_done <= 1'b0;
            else if (mode_q == 3'h4 && pin_q && !compare_output_pin && !wr_q)
                single_done <= 1'b1;
        end
    end

    a_rdata_idle_zero: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_pulse_write_low: assert property (ctrl_wr && wdata[2:1] == 2'b10 |=> !compare_output_pin)
        else $error("pin not low after pulse mode write");
    a_pwm_entry_low: assert property (ctrl_wr && wdata[2:1] == 2'b11 && !is_pwm |=> !compare_output_pin)
        else $error("pin not low on entering pwm");
    a_single_stays_low: assert property (single_done |-> !compare_output_pin)
        else $error("extra pulse after single pulse");
    a_irq_needs_enable: assert property (!ie_q |-> !compare_irq)
        else $error("irq raised while disabled");
    a_event_readback: assert property (rd && addr == `OC_REG_EVENT |=> rdata[15:2] == 14'h0000 && rdata[1] == ie_q)
        else $error("event register readback wrong");
    a_unmapped_zero: assert property (rd && addr > `OC_REG_EVENT |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_fault_holds_low: assert property ((mode_q == 3'h7 && !pwm_fault_n) [*5] |-> !compare_output_pin)
        else $error("pin not low during fault");

    cover property (single_done);
    cover property (mode_q == 3'h7 && !pwm_fault_n);
    cover property (is_pwm && $rose(compare_output_pin));
endmodule

bind output_compare_pulse_pwm output_compare_monitor i_mon (
    .clk                (clk),
    .rst                (rst),
    .addr               (addr),
    .wdata              (wdata),
    .wr                 (wr),
    .rd                 (rd),
    .rdata              (rdata),
    .pwm_fault_n        (pwm_fault_n),
    .compare_output_pin (compare_output_pin),
    .compare_irq        (compare_irq)
);
`default_nettype wire

// File: tb/pin_load.sv
// external load on the compare pin: counts pulses, drives the fault pin
`timescale 1ns/10ps
`default_nettype none

module pin_load (
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    // pin side
    input  wire         compare_output_pin,
    input  wire         fault_req,
    output wire         pwm_fault_n,
    // observed pulses
    output logic [15:0] rises,
    output logic [15:0] highs
);
    logic pin_q;

    // fault line is driven hard both ways, no pull-up to rely on
    assign pwm_fault_n = !fault_req;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b0;
            rises <= 16'h0000;
            highs <= 16'h0000;
        end else begin
            pin_q <= compare_output_pin;
            if (compare_output_pin)
                highs <= highs + 16'h0001;
            if (compare_output_pin && !pin_q)
                rises <= rises + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_output_compare_pulse_pwm.sv
// testbench for the output compare channel
`timescale 1ns/10ps
`default_nettype none
`include "oc_defines.vh"

module tb_output_compare_pulse_pwm;
    logic                  clk;
    logic                  rst;
    logic [`OC_ADDR_W-1:0] addr;
    logic [`OC_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
    wire  [`OC_DATA_W-1:0] rdata;
    logic                  fault_req;
    wire                   pwm_fault_n;
    wire                   pin;
    wire                   irq;
    wire  [15:0]           rises;
    wire  [15:0]           highs;
    logic [15:0]           r0;
    logic [15:0]           h0;
    logic [15:0]           duty_tab [0:3];
    int                    miscompares;
    int                    check_count;
    int                    cycles;
    int                    i;

    output_compare_pulse_pwm i_dut (
        .clk                (clk),
        .rst                (rst),
        .addr               (addr),
        .wdata              (wdata),
        .wr                 (wr),
        .rd                 (rd),
        .rdata              (rdata),
        .pwm_fault_n        (pwm_fault_n),
        .compare_output_pin (pin),
        .compare_irq        (irq)
    );

    pin_load i_load (
        .clk                (clk),
        .rst                (rst),
        .compare_output_pin (pin),
        .fault_req          (fault_req),
        .pwm_fault_n        (pwm_fault_n),
        .rises              (rises),
        .highs              (highs)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task summarize;
        begin
            $display("checks %0d, mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task wr_reg(input [`OC_ADDR_W-1:0] a, input [`OC_DATA_W-1:0] d);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= d;
            wr    <= 1'b1;
            @(posedge clk);
            wr    <= 1'b0;
        end
    endtask

    // read answer stands one cycle only, sampled just after the taking edge
    task rd_chk(input [`OC_ADDR_W-1:0] a, input [`OC_DATA_W-1:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            rd   <= 1'b0;
            #1;
            chk(rdata, exp);
        end
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            summarize;
        end
    end

    initial begin
        miscompares = 0;
        check_count = 0;
        cycles      = 0;
        addr        = 4'h0;
        wdata       = 16'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        fault_req   = 1'b0;
        rst         = 1'b1;
        duty_tab[0] = 16'h0007;
        duty_tab[1] = 16'h0000;
        duty_tab[2] = 16'h0009;
        duty_tab[3] = 16'h000A;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OC_REG_CTRL, 16'h0000);
        rd_chk(`OC_REG_EVENT, 16'h0000);
        wr_reg(4'hF, 16'hFFFF);
        rd_chk(4'hF, 16'h0000);
        // single pulse on the first timer, trailing edge raises the irq
        wr_reg(`OC_REG_T1_PERIOD, 16'h0014);
        wr_reg(`OC_REG_PRIMARY, 16'h0003);
        wr_reg(`OC_REG_SECONDARY, 16'h0007);
        wr_reg(`OC_REG_EVENT, 16'h0002);
        wr_reg(`OC_REG_CTRL, 16'h0004);
        r0 = rises;
        h0 = highs;
        wr_reg(`OC_REG_T1_CTRL, 16'h8000);
        repeat (60) @(posedge clk);
        chk(rises - r0, 16'h0001);
        chk(highs - h0, 16'h0004);
        chk({15'h0000, irq}, 16'h0001);
        rd_chk(`OC_REG_EVENT, 16'h0003);
        wr_reg(`OC_REG_CTRL, 16'h0004);
        repeat (30) @(posedge clk);
        chk(rises - r0, 16'h0002);
        chk(highs - h0, 16'h0008);
        wr_reg(`OC_REG_EVENT, 16'h0000);
        // flag clears on the edge that takes the write; look once it has settled
        #1;
        chk({15'h0000, irq}, 16'h0000);
        rd_chk(`OC_REG_EVENT, 16'h0000);
        // continuous pulses on the second timer, shorter period than the first
        wr_reg(`OC_REG_T2_PERIOD, 16'h0009);
        wr_reg(`OC_REG_PRIMARY, 16'h0002);
        wr_reg(`OC_REG_SECONDARY, 16'h0005);
        wr_reg(`OC_REG_CTRL, 16'h000D);
        wr_reg(`OC_REG_T2_CTRL, 16'h8000);
        r0 = rises;
        for (i = 0; i < 40 && rises == r0; i++)
            @(posedge clk);
        r0 = rises;
        repeat (95) @(posedge clk);
        chk(rises - r0, 16'h0009);
        wr_reg(`OC_REG_EVENT, 16'h0000);
        repeat (12) @(posedge clk);
        rd_chk(`OC_REG_EVENT, 16'h0001);
        // pwm: duty loaded while stopped, primary locked, secondary copied at wrap
        wr_reg(`OC_REG_T2_CTRL, 16'h0000);
        wr_reg(`OC_REG_T2_COUNT, 16'h0000);
        wr_reg(`OC_REG_PRIMARY, 16'h0004);
        wr_reg(`OC_REG_SECONDARY, 16'h0007);
        wr_reg(`OC_REG_CTRL, 16'h000E);
        wr_reg(`OC_REG_PRIMARY, 16'h0001);
        rd_chk(`OC_REG_PRIMARY, 16'h0004);
        h0 = highs;
        wr_reg(`OC_REG_T2_CTRL, 16'h8000);
        repeat (7) @(posedge clk);
        chk(highs - h0, 16'h0003);
        repeat (20) @(posedge clk);
        rd_chk(`OC_REG_PRIMARY, 16'h0007);
        // any ten-cycle window holds exactly duty high counts
        for (i = 0; i < 4; i++) begin
            wr_reg(`OC_REG_SECONDARY, duty_tab[i]);
            repeat (25) @(posedge clk);
            h0 = highs;
            repeat (10) @(posedge clk);
            chk(highs - h0, duty_tab[i]);
        end
        // fault in mode 111 latches pin low until control is rewritten with another mode
        wr_reg(`OC_REG_EVENT, 16'h0002);
        wr_reg(`OC_REG_CTRL, 16'h000F);
        fault_req <= 1'b1;
        repeat (8) @(posedge clk);
        chk({15'h0000, pin}, 16'h0000);
        chk({15'h0000, irq}, 16'h0001);
        rd_chk(`OC_REG_CTRL, 16'h001F);
        @(posedge clk);
        fault_req <= 1'b0;
        h0 = highs;
        repeat (12) @(posedge clk);
        chk(highs - h0, 16'h0000);
        wr_reg(`OC_REG_CTRL, 16'h000E);
        rd_chk(`OC_REG_CTRL, 16'h000E);
        summarize;
    end
endmodule
`default_nettype wire
